// ---- hw/gpm_pkg.sv ----
// Purpose: shared constants and types for the gpio pin function multiplexer
// Assumes: selection codes arrive as plain inputs, no software bus in this block
// Notes: one selection code of two bits per pin, code 0 is the default function

package gpm_pkg;

  // --------------------------------------------------------------------------
  // selection codes
  // --------------------------------------------------------------------------
  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SEL_ALT1 = 2'h1;
  localparam logic [1:0] SEL_ALT2 = 2'h2;
  localparam logic [1:0] SEL_ALT3 = 2'h3;

  // --------------------------------------------------------------------------
  // group sizes and reset values
  // --------------------------------------------------------------------------
  localparam int GROUP_ONE_PINS = 8;
  localparam int GROUP_FIVE_PINS = 4;
  localparam int GROUP_SIX_PINS = 8;
  localparam logic [15:0] GROUP_ONE_SEL_RST = 16'h0000;
  localparam logic [7:0] GROUP_FIVE_SEL_RST = 8'h00;
  localparam logic [15:0] GROUP_SIX_SEL_RST = 16'h0000;
  localparam logic KBC_LINE_SEL_RST = 1'h0;

  // one pin at the pad: output value and output enable (low drives)
  typedef struct packed {
    logic outVal;
    logic oeLow;
  } gpm_pad_drive_type;

  // sources offered to the mux for one pin
  typedef struct packed {
    logic gpioOut;
    logic gpioOeLow;
    logic gpioOpenDrain;
    logic irqOpenDrain;
  } gpm_gpio_ctl_type;

endpackage : gpm_pkg

// ---- hw/gpm_pin_mux.sv ----
// Purpose: pin function multiplexer for the general purpose pins and rom bus pins
// Assumes: selections held by configuration logic outside, single clock core_clk
// Notes: rom pins in their original role follow the external peripheral bus
//
// Behaviour
// - after reset the rom data, select and output enable pins act as the external peripheral bus.
// - rom data pins can never be open drain while they carry rom data.
// - the shared keyboard port pin carries line a or line b by one select bit, line a by default.
// - a pin routed to an interrupt request drives push-pull or open drain as configured, except the system management interrupt on pins 0 and 12, always push-pull.
// - the infrared transmit pin defaults low and stays low while the infrared block is idle.

`timescale 1ns/1ps

module gpm_pin_mux (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] groupOneSel,
  input wire logic [7:0] groupFiveSel,
  input wire logic [15:0] groupSixSel,
  input wire logic kbcLineSel,
  input wire gpm_pkg::gpm_gpio_ctl_type [19:0] gpioCtl,
  input wire logic [19:0] padIn,
  input wire logic [7:0] romDataOut,
  input wire logic romDataOeLow,
  input wire logic romSelectLow,
  input wire logic romOutputEnableLow,
  input wire logic [15:0] irqReq,
  input wire logic systemMgmtIrqLow,
  input wire logic watchdogOutput,
  input wire logic ledDrive,
  input wire logic infraredTransmitAlt,
  input wire logic infraredActive,
  input wire logic kbcLineAOut,
  input wire logic kbcLineBOut,
  output gpm_pkg::gpm_pad_drive_type [19:0] padDrive,
  output logic [19:0] gpioIn,
  output logic [7:0] romDataIn,
  output logic ringIndicateLow,
  output logic infraredReceiveAlt,
  output logic [2:0] eitherEdgeIrqInput,
  output logic kbcLineIn
);

  // --------------------------------------------------------------------------
  // selection state
  // --------------------------------------------------------------------------
  // pin order: 0..7 group one, 8..11 group five (50,52,53,54), 12..19 group six
  logic [15:0] g1Sel_reg;
  logic [7:0] g5Sel_reg;
  logic [15:0] g6Sel_reg;
  logic kbcSel_reg;
  logic [19:0] padMeta_reg;
  logic [19:0] padSync_reg;
  gpm_pkg::gpm_pad_drive_type [19:0] drive_next;
  logic [39:0] allSel;

  // selections captured every edge, defaults under reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      g1Sel_reg <= gpm_pkg::GROUP_ONE_SEL_RST;
      g5Sel_reg <= gpm_pkg::GROUP_FIVE_SEL_RST;
      g6Sel_reg <= gpm_pkg::GROUP_SIX_SEL_RST;
      kbcSel_reg <= gpm_pkg::KBC_LINE_SEL_RST;
    end else begin
      g1Sel_reg <= groupOneSel;
      g5Sel_reg <= groupFiveSel;
      g6Sel_reg <= groupSixSel;
      kbcSel_reg <= kbcLineSel;
    end
  end

  // pad inputs pass two flip-flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      padMeta_reg <= 20'h0000_0;
      padSync_reg <= 20'h0000_0;
    end else begin
      padMeta_reg <= padIn;
      padSync_reg <= padMeta_reg;
    end
  end

  assign allSel = {g6Sel_reg, g5Sel_reg, g1Sel_reg};

  // drive helpers: push-pull or open drain
  function automatic gpm_pkg::gpm_pad_drive_type drvOut(input logic v, input logic od);
    gpm_pkg::gpm_pad_drive_type d;
    d.outVal = v;
    d.oeLow = od ? v : 1'b0; // open drain releases the pad for a one
    return d;
  endfunction : drvOut

  function automatic gpm_pkg::gpm_pad_drive_type drvOff();
    gpm_pkg::gpm_pad_drive_type d;
    d.outVal = 1'b0;
    d.oeLow = 1'b1;
    return d;
  endfunction : drvOff

  function automatic gpm_pkg::gpm_pad_drive_type drvGpio(input gpm_pkg::gpm_gpio_ctl_type c);
    gpm_pkg::gpm_pad_drive_type d;
    if (c.gpioOeLow) begin
      d = drvOff();
    end else begin
      d = drvOut(c.gpioOut, c.gpioOpenDrain);
    end
    return d;
  endfunction : drvGpio

  // --------------------------------------------------------------------------
  // per pin function selection
  // --------------------------------------------------------------------------
  // one case item per pin or pin group, one function per code
  always_comb begin
    logic [1:0] s;
    logic kbcOut;
    s = 2'h0;
    kbcOut = kbcSel_reg ? kbcLineBOut : kbcLineAOut;
    for (int p = 0; p < 20; p++) begin
      s = allSel[2*p +: 2];
      drive_next[p] = drvGpio(gpioCtl[p]);
      case (p)
        0: if (s == gpm_pkg::SEL_ALT1) drive_next[p] = drvOut(systemMgmtIrqLow, 1'b0);
        1: if (s == gpm_pkg::SEL_ALT1 || s == gpm_pkg::SEL_ALT2) drive_next[p] = drvOff(); // ring or edge input
        2: begin
          if (s == gpm_pkg::SEL_ALT1) drive_next[p] = drvOut(watchdogOutput, 1'b0);
          if (s == gpm_pkg::SEL_ALT2) drive_next[p] = drvOut(kbcOut, 1'b1);
          if (s == gpm_pkg::SEL_ALT3) drive_next[p] = drvOff();
        end
        3: if (s == gpm_pkg::SEL_ALT1) drive_next[p] = drvOut(ledDrive, 1'b0);
        4: if (s == gpm_pkg::SEL_ALT1) drive_next[p] = drvOff();
        // transmit held low while idle
        5: if (s == gpm_pkg::SEL_ALT1) begin
          drive_next[p] = drvOut(infraredTransmitAlt & infraredActive, 1'b0);
        end
        6, 7: if (s == gpm_pkg::SEL_DEFAULT) drive_next[p] = drvOff(); // original floppy role is outside
        8: if (s == gpm_pkg::SEL_DEFAULT) drive_next[p] = drvOff();
          else if (s == gpm_pkg::SEL_ALT1) drive_next[p] = drvOut(irqReq[15], gpioCtl[p].irqOpenDrain);
        9: case (s)
          gpm_pkg::SEL_DEFAULT: drive_next[p] = drvOff();
          gpm_pkg::SEL_ALT2: drive_next[p] = drvOut(irqReq[6], gpioCtl[p].irqOpenDrain);
          gpm_pkg::SEL_ALT3: drive_next[p] = drvOut(systemMgmtIrqLow, gpioCtl[p].irqOpenDrain);
          default: ;
        endcase
        10, 11: case (s)
          gpm_pkg::SEL_DEFAULT: begin
            drive_next[p] = drvOut((p == 10) ? romSelectLow : romOutputEnableLow, 1'b0);
          end
          gpm_pkg::SEL_ALT1: drive_next[p] = drvOut(irqReq[p - 2], gpioCtl[p].irqOpenDrain);
          gpm_pkg::SEL_ALT3: drive_next[p] = drvOff();
          default: ;
        endcase
        default: case (s)
          // rom data: push-pull only, open drain never applied here
          gpm_pkg::SEL_DEFAULT: begin
            drive_next[p] = romDataOeLow ? drvOff() : drvOut(romDataOut[p - 12], 1'b0);
          end
          gpm_pkg::SEL_ALT1: drive_next[p] = drvOut(irqReq[p - 12], gpioCtl[p].irqOpenDrain);
          gpm_pkg::SEL_ALT3: begin
            case (p)
              12: drive_next[p] = drvOut(systemMgmtIrqLow, 1'b0);
              13: drive_next[p] = drvOut(ledDrive, 1'b0);
              15: drive_next[p] = drvOut(watchdogOutput, 1'b0);
              14: drive_next[p] = drvOff(); // ring input
              16: drive_next[p] = drvOut(kbcOut, 1'b1);
              default: ; // no function here, gpio drive stands
            endcase
          end
          default: ;
        endcase
      endcase
    end
  end

  // pad drives registered; reset releases every pad except pin 5, which is driven low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int p = 0; p < 20; p++) begin
        padDrive[p] <= drvOff();
      end
      padDrive[5] <= drvOut(1'b0, 1'b0);
    end else begin
      padDrive <= drive_next;
    end
  end

  // --------------------------------------------------------------------------
  // input routing
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gpioIn <= 20'h0000_0;
      romDataIn <= 8'h00;
      ringIndicateLow <= 1'b1;
      infraredReceiveAlt <= 1'b1;
      eitherEdgeIrqInput <= 3'h0;
      kbcLineIn <= 1'b1;
    end else begin
      gpioIn <= padSync_reg;
      romDataIn <= padSync_reg[19:12];
      ringIndicateLow <= (g1Sel_reg[3:2] == gpm_pkg::SEL_ALT1) ? padSync_reg[1] :
                         (g6Sel_reg[5:4] == gpm_pkg::SEL_ALT3) ? padSync_reg[14] : 1'b1;
      infraredReceiveAlt <= (g1Sel_reg[9:8] == gpm_pkg::SEL_ALT1) ? padSync_reg[4] : 1'b1;
      eitherEdgeIrqInput[0] <= ((g1Sel_reg[3:2] == gpm_pkg::SEL_ALT2) & padSync_reg[1]) |
                               ((g1Sel_reg[5:4] == gpm_pkg::SEL_ALT3) & padSync_reg[2]);
      eitherEdgeIrqInput[1] <= (g5Sel_reg[5:4] == gpm_pkg::SEL_ALT3) & padSync_reg[10];
      eitherEdgeIrqInput[2] <= (g5Sel_reg[7:6] == gpm_pkg::SEL_ALT3) & padSync_reg[11];
      kbcLineIn <= (g1Sel_reg[5:4] == gpm_pkg::SEL_ALT2) ? padSync_reg[2] :
                   (g6Sel_reg[9:8] == gpm_pkg::SEL_ALT3) ? padSync_reg[16] : 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  chk_rom_default_after: assert property (@(posedge core_clk)
    $fell(srst) |-> ##1 padDrive[10].outVal == $past(romSelectLow))
    else $error("rom select not on pad after reset");
  // the edge right after reset still shows the released reset drive
  chk_rom_no_od: assert property (@(posedge core_clk) disable iff (srst)
    (!$past(srst) && $past(g6Sel_reg[1:0]) == 2'h0 && !$past(romDataOeLow)) |-> !padDrive[12].oeLow)
    else $error("rom data pin released in rom role");
  chk_kbc_line_sel: assert property (@(posedge core_clk) disable iff (srst)
    ($past(g1Sel_reg[5:4]) == 2'h2 && $past(kbcSel_reg) == 1'b0) |-> padDrive[2].outVal == $past(kbcLineAOut))
    else $error("keyboard line a not selected");
  chk_irq_od_drive: assert property (@(posedge core_clk) disable iff (srst)
    ($past(g6Sel_reg[1:0]) == 2'h1 && $past(gpioCtl[12].irqOpenDrain) && $past(irqReq[0])) |-> padDrive[12].oeLow)
    else $error("open drain irq drove high");
  chk_one_function: assert property (@(posedge core_clk) disable iff (srst)
    ($past(g1Sel_reg[1:0]) == 2'h1) |-> padDrive[0].outVal == $past(systemMgmtIrqLow) && !padDrive[0].oeLow)
    else $error("pin 0 function wrong");
  chk_irtx_idle_low: assert property (@(posedge core_clk) disable iff (srst)
    ($past(g1Sel_reg[11:10]) == 2'h1 && !$past(infraredActive)) |-> padDrive[5].outVal == 1'b0)
    else $error("infrared transmit not low while idle");

endmodule : gpm_pin_mux

// ---- testbench/gpio_pin_function_mux_test.sv ----
// Purpose: self-checking bench for the gpio pin function multiplexer
// Assumes: selections and sources are levels driven at the rising edge
// Notes: checks wait four edges so select, drive and pad sync stages settle
`timescale 1ns/1ps

module gpio_pin_function_mux_test;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [39:0] selAll = 40'h00_0000_0000; // two bits per pin, pin 0 lowest
  logic kbcLineSel = 1'b0;
  gpm_pkg::gpm_gpio_ctl_type [19:0] gpioCtl = '0;
  logic [19:0] padIn = 20'h0_0000;
  logic [7:0] romDataOut = 8'h00;
  logic [15:0] irqReq = 16'h0000;
  logic [9:0] misc = 10'h000; // single-bit function sources, packed
  gpm_pkg::gpm_pad_drive_type [19:0] padDrive;
  logic [19:0] gpioIn;
  logic [7:0] romDataIn;
  logic ringIndicateLow;
  logic infraredReceiveAlt;
  logic [2:0] eitherEdgeIrqInput;
  logic kbcLineIn;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;

  // clock of 25 ns period
  always #12.5 core_clk = ~core_clk;

  gpm_pin_mux dut (.core_clk(core_clk), .srst(srst), .groupOneSel(selAll[15:0]), .groupFiveSel(selAll[23:16]),
    .groupSixSel(selAll[39:24]), .kbcLineSel(kbcLineSel), .gpioCtl(gpioCtl), .padIn(padIn),
    .romDataOut(romDataOut), .romDataOeLow(misc[0]), .romSelectLow(misc[1]), .romOutputEnableLow(misc[2]),
    .irqReq(irqReq), .systemMgmtIrqLow(misc[3]), .watchdogOutput(misc[4]), .ledDrive(misc[5]),
    .infraredTransmitAlt(misc[6]), .infraredActive(misc[7]), .kbcLineAOut(misc[8]), .kbcLineBOut(misc[9]),
    .padDrive(padDrive), .gpioIn(gpioIn), .romDataIn(romDataIn), .ringIndicateLow(ringIndicateLow),
    .infraredReceiveAlt(infraredReceiveAlt), .eitherEdgeIrqInput(eitherEdgeIrqInput), .kbcLineIn(kbcLineIn));

  // ---------------------------------------------------------------------------
  // expectations and comparison
  // ---------------------------------------------------------------------------
  // pad pair {outVal, oeLow} of a driven output; open drain releases the pad for a one
  function automatic logic [1:0] drv(input logic v, input logic od);
    return {v, od & v};
  endfunction : drv

  // returns {kind, outVal, oeLow}; kind 1 function or gpio, 2 irq, 3 peripheral bus
  function automatic logic [3:0] expect_pad(input int i);
    logic [1:0] s;
    logic [1:0] g;
    logic kv;
    int b;
    s = selAll[2*i+:2];
    kv = kbcLineSel ? misc[9] : misc[8];
    g = gpioCtl[i].gpioOeLow ? 2'h1 : drv(gpioCtl[i].gpioOut, gpioCtl[i].gpioOpenDrain);
    b = (i >= 12) ? i - 12 : (i == 8) ? 15 : (i == 9) ? 6 : (i == 10) ? 8 : 9;
    if (((i >= 12 || i == 8 || i == 10 || i == 11) && s == 2'h1) || (i == 9 && s == 2'h2))
      return {2'h2, drv(irqReq[b], gpioCtl[i].irqOpenDrain)};
    if (i == 9 && s == 2'h3)
      return {2'h2, drv(misc[3], gpioCtl[i].irqOpenDrain)};
    if (i >= 12 && s == 2'h0)
      return {2'h3, (misc[0] ? 2'h1 : {romDataOut[i-12], 1'b0})};
    if (i >= 10 && s == 2'h0)
      return {2'h3, ((i == 10) ? misc[1] : misc[2]), 1'b0};
    case (s)
      2'h0: begin
        if (i >= 6) g = 2'h1; // floppy and clock defaults live outside
      end
      2'h1: begin
        case (i)
          0: g = drv(misc[3], 1'b0);
          1, 4: g = 2'h1; // input roles release the pad
          2: g = drv(misc[4], 1'b0);
          3: g = drv(misc[5], 1'b0);
          5: g = drv(misc[6] & misc[7], 1'b0);
          default: ;
        endcase
      end
      2'h2: begin
        if (i == 1) g = 2'h1;
        if (i == 2) g = drv(kv, 1'b1);
      end
      default: begin
        case (i)
          2, 10, 11, 14: g = 2'h1;
          12: g = drv(misc[3], 1'b0);
          13: g = drv(misc[5], 1'b0);
          15: g = drv(misc[4], 1'b0);
          16: g = drv(kv, 1'b1);
          default: ;
        endcase
      end
    endcase
    return {2'h1, g};
  endfunction : expect_pad

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // compares every pad and input path against the current setup, rom data input only while group six is all on code 0
  task automatic check_all();
    logic [3:0] e;
    logic kv;
    logic ring;
    logic kin;
    logic [2:0] edg;
    kv = kbcLineSel ? misc[9] : misc[8];
    ring = (selAll[3:2] == 2'h1) ? padIn[1] : (selAll[29:28] == 2'h3) ? padIn[14] : 1'b1;
    kin = (selAll[5:4] == 2'h2) ? padIn[2] : (selAll[33:32] == 2'h3) ? padIn[16] : 1'b1;
    edg = {(selAll[23:22] == 2'h3) & padIn[11], (selAll[21:20] == 2'h3) & padIn[10],
           ((selAll[3:2] == 2'h2) & padIn[1]) | ((selAll[5:4] == 2'h3) & padIn[2])};
    for (int i = 0; i < 20; i++) begin
      e = expect_pad(i);
      case (e[3:2])
        2'h2: check(8'(padDrive[i]), 8'(e[1:0]));
        2'h3: check(8'(padDrive[i]), 8'(e[1:0]));
        default: check(8'(padDrive[i]), 8'(e[1:0]));
      endcase
      check(8'(gpioIn[i]), 8'(padIn[i]));
    end
    if (selAll[39:24] == 16'h0000) check(romDataIn, padIn[19:12]);
    if (selAll[21:20] == 2'h0) check(8'(padDrive[10].outVal), 8'(misc[1]));
    if (selAll[23:22] == 2'h0) check(8'(padDrive[11].outVal), 8'(misc[2]));
    if (selAll[5:4] == 2'h2) check(8'(padDrive[2].outVal), 8'(kv));
    if (selAll[33:32] == 2'h3) check(8'(padDrive[16].outVal), 8'(kv));
    check(8'(ringIndicateLow), 8'(ring));
    check(8'(infraredReceiveAlt), 8'((selAll[9:8] == 2'h1) ? padIn[4] : 1'b1));
    check(8'(eitherEdgeIrqInput), 8'(edg));
    check(8'(kbcLineIn), 8'(kin));
  endtask : check_all

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  // reset state, then uniform codes 0..3 followed by random setups
  initial begin
    logic [39:0] sel;
    logic [9:0] m;
    void'($urandom(20));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    for (int i = 0; i < 20; i++) check(8'(padDrive[i]), (i == 5) ? 8'h00 : 8'h01);
    check(8'({ringIndicateLow, infraredReceiveAlt, kbcLineIn, eitherEdgeIrqInput}), 8'h38);
    @(posedge core_clk);
    srst <= 1'b0;
    for (int n = 0; n < 300; n++) begin
      @(posedge core_clk);
      sel = (n < 4) ? {20{n[1:0]}} : 40'({$urandom, $urandom});
      m = 10'($urandom);
      if (sel[39:24] != 16'h0000) m[1] = 1'b1;
      selAll <= sel;
      kbcLineSel <= (n < 2) ? n[0] : 1'($urandom);
      gpioCtl <= 80'({$urandom, $urandom, $urandom});
      padIn <= 20'($urandom);
      romDataOut <= 8'($urandom);
      irqReq <= 16'($urandom);
      misc <= m;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      check_all();
    end
    report_and_stop();
  end

  // hang guard, well above the 1504 cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
endmodule : gpio_pin_function_mux_test
